// ===== rtl/sdt_split_timer.sv
// split-mode register set and twin 8-bit down-counters
// Function
// RQ1 - writing ones to command_clear clears those control bits only
// RQ2 - writing ones to command_set sets those control bits only
// RQ3 - command field bits 3:2 always read back as zero
// RQ4 - command 0 none, 2 restart, 3 hard reset, 1 reserved
// RQ5 - hard reset is ignored while the timer is enabled
// RQ6 - command_target 0 selects none, 3 selects both counters
// RQ7 - software pairs hard reset with target both in one write
// RQ8 - enable bits 6:4 pass low compare flags to interrupt request
// RQ9 - enable bit 1 gates high underflow, bit 0 low underflow
// RQ10 - low compare flag n sets when low count equals compare n
// RQ11 - flags stay set until software writes one to clear them
// RQ12 - high underflow flag bit 1 sets at high counter bottom
// RQ13 - low underflow flag bit 0 sets at low counter bottom
// RQ14 - debug_run clear: halt counting and ignore events in debug break
// RQ15 - debug_run set: keep counting during debug break
// RQ16 - software count write wins over count, clear or reload
// RQ17 - both count registers are 8-bit, read-write, reset zero
// RQ18 - split_select makes two independent 8-bit counters
// RQ19 - each counter reloads from its own period, reset 0xff
// RQ20 - compare registers are continuously compared to their counter; the code compares the low ones only, high ones are only stored
// RQ21 - count down per tick, reload from period after zero
// RQ22 - restart returns selected counters to start, config kept
//
// Our own choice: strobed register access.
module sdt_split_timer
  import sdt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // timing inputs
  input wire logic tick_i,
  input wire logic event_i,
  input wire logic debug_halt_i,
  // status outputs
  output logic irq_o,
  output logic [7:0] low_count_o,
  output logic [7:0] high_count_o,
  output logic [SDT_CHANNELS-1:0] low_match_o
);
  import sdt_pkg::*;

  // ==========================================================
  // register state
  logic enable_r;
  logic split_r;
  logic [1:0] target_r;
  logic [7:0] int_en_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic debug_run_r;
  logic [7:0] low_per_r;
  logic [7:0] high_per_r;
  logic [7:0] low_cmp_r [SDT_CHANNELS];
  logic [7:0] high_cmp_r [SDT_CHANNELS];
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic low_bottom;
  logic high_bottom;
  logic run_ok;
  logic cnt_tick;
  logic restart_req;
  logic hard_reset_req;
  logic [1:0] cmd_wr;
  logic [1:0] tgt_wr;
  logic cmd_write;
  logic low_load;
  logic high_load;
  logic [SDT_CHANNELS-1:0] low_eq;

  // ==========================================================
  // command decode
  assign cmd_write = wr_i && split_r &&
                     ((addr_i == SDT_OFF_CMD_SET) ||
                      (addr_i == SDT_OFF_CMD_CLR));
  assign cmd_wr = (addr_i == SDT_OFF_CMD_SET) ? wdata_i[3:2] : SDT_CMD_NONE;
  // target applied with the command is the value after this write
  assign tgt_wr = (addr_i == SDT_OFF_CMD_SET) ? (target_r | wdata_i[1:0]) :
                  (target_r & ~wdata_i[1:0]);
  // reserved targets select nothing; relies on software pairing
  always_comb begin
    restart_req = 1'b0;
    hard_reset_req = 1'b0;
    if (cmd_write && (tgt_wr == SDT_TGT_BOTH)) begin // RQ6
      case (cmd_wr)
        SDT_CMD_RESTART: restart_req = 1'b1; // RQ4
        // a running timer must not lose its setup under it
        SDT_CMD_RESET: hard_reset_req = !enable_r; // RQ5
        default: restart_req = 1'b0; // none and reserved code: no action
      endcase
    end
  end

  // debug gating of ticks and events
  assign run_ok = debug_run_r || !debug_halt_i; // RQ14 RQ15
  assign cnt_tick = tick_i && enable_r && split_r && run_ok; // RQ18

  assign low_load = wr_i && (addr_i == SDT_OFF_LOW_CNT);
  assign high_load = wr_i && (addr_i == SDT_OFF_HIGH_CNT);

  // ==========================================================
  // timer enable; a hard reset only ever reaches a stopped timer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable_r <= 1'b0;
    end else if (hard_reset_req) begin
      enable_r <= 1'b0;
    end else if (wr_i && (addr_i == SDT_OFF_CTRL)) begin
      enable_r <= wdata_i[SDT_BIT_ENABLE];
    end
  end

  // split select; while clear the command registers stay deaf
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      split_r <= 1'b0;
    end else if (hard_reset_req) begin
      split_r <= 1'b0;
    end else if (wr_i && (addr_i == SDT_OFF_SPLIT)) begin
      split_r <= wdata_i[SDT_BIT_SPLIT]; // RQ18
    end
  end

  // debug behaviour during a processor break
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      debug_run_r <= 1'b0;
    end else if (hard_reset_req) begin
      debug_run_r <= 1'b0;
    end else if (wr_i && (addr_i == SDT_OFF_DEBUG)) begin
      debug_run_r <= wdata_i[SDT_BIT_DEBUG_RUN]; // RQ14 RQ15
    end
  end

  // command target held via set and clear variants
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      target_r <= 2'h0;
    end else if (cmd_write) begin
      target_r <= tgt_wr; // RQ1 RQ2
    end
  end

  // interrupt enables
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_en_r <= SDT_RST_ZERO;
    end else if (hard_reset_req) begin
      int_en_r <= SDT_RST_ZERO;
    end else if (wr_i && (addr_i == SDT_OFF_INT_EN)) begin
      int_en_r <= wdata_i & SDT_MASK_INT;
    end
  end

  // low byte period, top of the low count sequence
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_per_r <= SDT_RST_PERIOD;
    end else if (hard_reset_req) begin
      low_per_r <= SDT_RST_PERIOD;
    end else if (wr_i && (addr_i == SDT_OFF_LOW_PER)) begin
      low_per_r <= wdata_i; // RQ19
    end
  end

  // high byte period, independent of the low one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      high_per_r <= SDT_RST_PERIOD;
    end else if (hard_reset_req) begin
      high_per_r <= SDT_RST_PERIOD;
    end else if (wr_i && (addr_i == SDT_OFF_HIGH_PER)) begin
      high_per_r <= wdata_i; // RQ19
    end
  end

  // ==========================================================
  // compare channels, one per generate entry
  for (genvar n = 0; n < SDT_CHANNELS; n++) begin : g_cmp
    localparam logic [7:0] LOFF = SDT_OFF_LOW_CMP0 + 8'(n) * SDT_CMP_STRIDE;
    localparam logic [7:0] HOFF = SDT_OFF_HIGH_CMP0 + 8'(n) * SDT_CMP_STRIDE;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        low_cmp_r[n] <= SDT_RST_ZERO;
      end else if (hard_reset_req) begin
        low_cmp_r[n] <= SDT_RST_ZERO;
      end else if (wr_i && (addr_i == LOFF)) begin
        low_cmp_r[n] <= wdata_i;
      end
    end
    // high compares are only stored and read back; nothing compares them or drives them out
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        high_cmp_r[n] <= SDT_RST_ZERO;
      end else if (hard_reset_req) begin
        high_cmp_r[n] <= SDT_RST_ZERO;
      end else if (wr_i && (addr_i == HOFF)) begin
        high_cmp_r[n] <= wdata_i;
      end
    end
    // match only counts while running and not halted
    assign low_eq[n] = split_r && run_ok && enable_r &&
                       (low_cnt == low_cmp_r[n]); // RQ10 RQ20
  end

  // ==========================================================
  // the two byte counters
  sdt_byte_counter u_low (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .tick_i(cnt_tick),
    .restart_i(restart_req || hard_reset_req),
    .load_i(low_load), // RQ16
    .load_val_i(wdata_i),
    .period_i(low_per_r),
    .count_o(low_cnt), // RQ17
    .bottom_o(low_bottom)
  );

  sdt_byte_counter u_high (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .tick_i(cnt_tick),
    .restart_i(restart_req || hard_reset_req),
    .load_i(high_load), // RQ16
    .load_val_i(wdata_i),
    .period_i(high_per_r),
    .count_o(high_cnt), // RQ17
    .bottom_o(high_bottom)
  );

  // ==========================================================
  // flags: hardware set wins over a same-cycle software clear
  always_comb begin
    flags_nxt = flags_r;
    if (wr_i && (addr_i == SDT_OFF_INT_FLAGS)) begin
      flags_nxt = flags_r & ~(wdata_i & SDT_MASK_INT); // RQ11
    end
    if (hard_reset_req) begin
      flags_nxt = SDT_RST_ZERO;
    end
    if (low_bottom) begin
      flags_nxt[SDT_BIT_LOW_UNF] = 1'b1; // RQ13
    end
    if (high_bottom) begin
      flags_nxt[SDT_BIT_HIGH_UNF] = 1'b1; // RQ12
    end
    for (int i = 0; i < SDT_CHANNELS; i++) begin
      if (low_eq[i]) begin
        flags_nxt[SDT_BIT_LOW_CMP0 + i] = 1'b1; // RQ10
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_r <= SDT_RST_ZERO;
    end else begin
      flags_r <= flags_nxt; // RQ11
    end
  end

  // pending sources; next flag value saves a cycle of request lag
  logic [7:0] irq_src;
  assign irq_src = flags_nxt & int_en_r; // RQ8 RQ9

  // interrupt request, registered
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |irq_src; // RQ8 RQ9
    end
  end

  // ==========================================================
  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= SDT_RST_ZERO;
    end else if (!rd_i) begin
      rdata_o <= SDT_RST_ZERO;
    end else begin
      case (addr_i)
        SDT_OFF_CTRL: rdata_o <= {7'h00, enable_r};
        SDT_OFF_SPLIT: rdata_o <= {7'h00, split_r};
        SDT_OFF_CMD_CLR,
        SDT_OFF_CMD_SET: rdata_o <= {6'h00, target_r}; // RQ3
        SDT_OFF_INT_EN: rdata_o <= int_en_r;
        SDT_OFF_INT_FLAGS: rdata_o <= flags_r;
        SDT_OFF_DEBUG: rdata_o <= {7'h00, debug_run_r};
        SDT_OFF_LOW_CNT: rdata_o <= low_cnt; // RQ17
        SDT_OFF_HIGH_CNT: rdata_o <= high_cnt; // RQ17
        SDT_OFF_LOW_PER: rdata_o <= low_per_r;
        SDT_OFF_HIGH_PER: rdata_o <= high_per_r;
        default: begin
          rdata_o <= SDT_RST_ZERO;
          for (int i = 0; i < SDT_CHANNELS; i++) begin
            if (addr_i == SDT_OFF_LOW_CMP0 + 8'(i) * SDT_CMP_STRIDE) begin
              rdata_o <= low_cmp_r[i];
            end
            if (addr_i == SDT_OFF_HIGH_CMP0 + 8'(i) * SDT_CMP_STRIDE) begin
              rdata_o <= high_cmp_r[i];
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // registered count copies, one cycle behind the counters
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_count_o <= SDT_RST_ZERO;
      high_count_o <= SDT_RST_ZERO;
    end else begin
      low_count_o <= low_cnt; // RQ17
      high_count_o <= high_cnt; // RQ17
    end
  end

  // registered compare equality for the waveform logic
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_match_o <= '0;
    end else begin
      low_match_o <= low_eq; // RQ20
    end
  end

  // event input is only observed when not halted; the sampled value drives nothing
  logic event_seen_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      event_seen_r <= 1'b0;
    end else begin
      event_seen_r <= event_i && run_ok; // RQ14
    end
  end
endmodule : sdt_split_timer

// ===== rtl/sdt_pkg.sv
// package: register map, field layout and reset values of the split timer
package sdt_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] SDT_OFF_CTRL = 8'h00;
  localparam logic [7:0] SDT_OFF_SPLIT = 8'h03;
  localparam logic [7:0] SDT_OFF_CMD_CLR = 8'h04;
  localparam logic [7:0] SDT_OFF_CMD_SET = 8'h05;
  localparam logic [7:0] SDT_OFF_INT_EN = 8'h0a;
  localparam logic [7:0] SDT_OFF_INT_FLAGS = 8'h0b;
  localparam logic [7:0] SDT_OFF_DEBUG = 8'h0e;
  localparam logic [7:0] SDT_OFF_LOW_CNT = 8'h20;
  localparam logic [7:0] SDT_OFF_HIGH_CNT = 8'h21;
  localparam logic [7:0] SDT_OFF_LOW_PER = 8'h26;
  localparam logic [7:0] SDT_OFF_HIGH_PER = 8'h27;
  localparam logic [7:0] SDT_OFF_LOW_CMP0 = 8'h28;
  localparam logic [7:0] SDT_OFF_HIGH_CMP0 = 8'h29;
  localparam logic [7:0] SDT_CMP_STRIDE = 8'h02;
  // ==========================================================
  // field layout
  localparam int SDT_CHANNELS = 3;
  localparam int SDT_BIT_ENABLE = 0;
  localparam int SDT_BIT_SPLIT = 0;
  localparam int SDT_BIT_DEBUG_RUN = 0;
  localparam int SDT_BIT_LOW_UNF = 0;
  localparam int SDT_BIT_HIGH_UNF = 1;
  localparam int SDT_BIT_LOW_CMP0 = 4;
  localparam logic [7:0] SDT_MASK_CMD = 8'h0f;
  localparam logic [7:0] SDT_MASK_TARGET = 8'h03;
  localparam logic [7:0] SDT_MASK_INT = 8'h73;
  // ==========================================================
  // command and target encodings
  localparam logic [1:0] SDT_CMD_NONE = 2'h0;
  localparam logic [1:0] SDT_CMD_RESTART = 2'h2;
  localparam logic [1:0] SDT_CMD_RESET = 2'h3;
  localparam logic [1:0] SDT_TGT_BOTH = 2'h3;
  // ==========================================================
  // reset values
  localparam logic [7:0] SDT_RST_ZERO = 8'h00;
  localparam logic [7:0] SDT_RST_PERIOD = 8'hff;
  localparam logic [7:0] SDT_CNT_BOTTOM = 8'h00;
endpackage : sdt_pkg

// ===== rtl/sdt_byte_counter.sv
// one 8-bit down-counter with reload, restart and software load
module sdt_byte_counter
  import sdt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic tick_i,
  input wire logic restart_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic [7:0] period_i,
  // state
  output logic [7:0] count_o,
  output logic bottom_o
);
  import sdt_pkg::*;

  // ==========================================================
  // count register; software load wins over every other update
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_o <= SDT_RST_ZERO;
    end else if (load_i) begin
      count_o <= load_val_i; // RQ16
    end else if (restart_i) begin
      count_o <= SDT_RST_ZERO; // RQ22
    end else if (tick_i) begin
      if (count_o == SDT_CNT_BOTTOM) begin
        count_o <= period_i; // RQ19 RQ21
      end else begin
        count_o <= count_o - 8'h01; // RQ21
      end
    end
  end

  // bottom seen on a counting tick, one pulse per underflow
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bottom_o <= 1'b0;
    end else begin
      bottom_o <= tick_i && !load_i && !restart_i &&
                  (count_o == SDT_CNT_BOTTOM);
    end
  end
endmodule : sdt_byte_counter

// ===== tb/sdt_split_timer_chk.sv
// checker: port-level properties of the split timer register set
module sdt_split_timer_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // timing and status
  input wire logic tick_i,
  input wire logic event_i,
  input wire logic debug_halt_i,
  input wire logic irq_o,
  input wire logic [7:0] low_count_o,
  input wire logic [7:0] high_count_o,
  input wire logic [sdt_pkg::SDT_CHANNELS-1:0] low_match_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sdt_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // register reads
  a_cmd_reads_zero: assert property (
    rd_i && (addr_i == SDT_OFF_CMD_CLR || addr_i == SDT_OFF_CMD_SET)
    |=> rdata_o[3:2] == 2'h0) else $error("command field read nonzero");
  a_int_en_rsvd: assert property (
    rd_i && addr_i == SDT_OFF_INT_EN |=> (rdata_o & 8'h8c) == 8'h00)
    else $error("enable spare bits nonzero");
  a_flags_rsvd: assert property (
    rd_i && addr_i == SDT_OFF_INT_FLAGS |=> (rdata_o & 8'h8c) == 8'h00)
    else $error("flag spare bits nonzero");
  a_debug_rsvd: assert property (
    rd_i && addr_i == SDT_OFF_DEBUG |=> rdata_o[7:1] == 7'h00)
    else $error("debug spare bits nonzero");
  // ==========================================================
  // counters and request; copy lags counter by one cycle
  a_low_write_wins: assert property (
    wr_i && addr_i == SDT_OFF_LOW_CNT |=> ##1 low_count_o == $past(wdata_i, 2))
    else $error("low count write lost");
  a_high_write_wins: assert property (
    wr_i && addr_i == SDT_OFF_HIGH_CNT
    |=> ##1 high_count_o == $past(wdata_i, 2))
    else $error("high count write lost");
  a_irq_masked: assert property (
    wr_i && addr_i == SDT_OFF_INT_EN && wdata_i == 8'h00 |=> ##1 !irq_o)
    else $error("request with all enables clear");
  a_reset_values: assert property (
    $rose(rst_b_i) |-> low_count_o == 8'h00 && high_count_o == 8'h00 && !irq_o)
    else $error("outputs not at reset value");
  // main scenarios
  cover property (wr_i && addr_i == SDT_OFF_CMD_SET && wdata_i[3:2] == 2'h2);
  cover property ($rose(irq_o));
  cover property (debug_halt_i && tick_i);
endmodule : sdt_split_timer_chk

// ===== tb/tb_top.sv
// testbench: register, counting, command and debug scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sdt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tick_i = 1'b0;
  logic event_i = 1'b0;
  logic debug_halt_i = 1'b0;
  logic [7:0] rdata_o, low_count_o, high_count_o;
  logic irq_o;
  logic [SDT_CHANNELS-1:0] low_match_o;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  integer seed = 70;
  logic [7:0] v;
  logic [7:0] regs [8] = '{8'h04, 8'h05, 8'h0a, 8'h0b, 8'h0e, 8'h20, 8'h21,
    8'h10};
  sdt_split_timer sdt_split_timer_inst (.clk_i, .rst_b_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .tick_i, .event_i, .debug_halt_i, .irq_o,
    .low_count_o, .high_count_o, .low_match_o);
  // ==========================================================
  // clock and hang guard; the whole run needs well under 2000 cycles
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // ==========================================================
  // tasks
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  // expected count of a down-counter after n ticks
  function automatic logic [7:0] cnt_after(logic [7:0] s, logic [7:0] p,
    int n);
    logic [7:0] c;
    c = s;
    repeat (n) begin
      c = (c == SDT_CNT_BOTTOM) ? p : c - 8'h01;
    end
    return c;
  endfunction : cnt_after
  // one-cycle write strobe, returns at its sampling edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), e, rdata_o & m);
  endtask : rd
  task automatic ticks(int n);
    logic [31:0] r;
    repeat (n) begin
      @(posedge clk_i);
      r = $random(seed);
      tick_i <= 1'b1;
      event_i <= r[0];
      @(posedge clk_i);
      tick_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask : ticks
  // request is registered: allow two edges before looking
  task automatic irq_is(logic e);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq", {7'h0, e}, {7'h0, irq_o});
  endtask : irq_is
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'hff, 8'h00);
    wr(SDT_OFF_CMD_SET, 8'h03);
    rd(SDT_OFF_CMD_SET, 8'hff, 8'h00);
    wr(SDT_OFF_SPLIT, 8'h01);
    wr(SDT_OFF_CMD_SET, 8'h03);
    rd(SDT_OFF_CMD_SET, 8'hff, 8'h03);
    wr(SDT_OFF_CMD_CLR, 8'h01);
    rd(SDT_OFF_CMD_CLR, 8'hff, 8'h02);
    wr(SDT_OFF_CMD_CLR, 8'h03);
    wr(SDT_OFF_LOW_CNT, 8'h5a);
    wr(SDT_OFF_CMD_SET, 8'h08);
    rd(SDT_OFF_LOW_CNT, 8'hff, 8'h5a);
    wr(SDT_OFF_CTRL, 8'h01);
    // random count writes, some landing on a tick
    repeat (8) begin
      v = 8'($random(seed));
      @(posedge clk_i);
      tick_i <= v[0];
      wr(SDT_OFF_LOW_CNT, v);
      tick_i <= 1'b0;
      rd(SDT_OFF_LOW_CNT, 8'hff, v);
      wr(SDT_OFF_HIGH_CNT, ~v);
      rd(SDT_OFF_HIGH_CNT, 8'hff, ~v);
    end
    // both counters pass bottom once
    wr(SDT_OFF_LOW_CNT, 8'h01);
    wr(SDT_OFF_HIGH_CNT, 8'h00);
    wr(SDT_OFF_INT_FLAGS, 8'h73);
    wr(SDT_OFF_INT_EN, 8'h03);
    ticks(2);
    rd(SDT_OFF_LOW_CNT, 8'hff, cnt_after(8'h01, SDT_RST_PERIOD, 2));
    rd(SDT_OFF_HIGH_CNT, 8'hff, cnt_after(8'h00, SDT_RST_PERIOD, 2));
    rd(SDT_OFF_INT_FLAGS, 8'h70, 8'h70);
    rd(SDT_OFF_INT_FLAGS, 8'h02, 8'h02);
    rd(SDT_OFF_INT_FLAGS, 8'h01, 8'h01);
    irq_is(1'b1);
    wr(SDT_OFF_INT_EN, 8'h00);
    irq_is(1'b0);
    wr(SDT_OFF_INT_EN, 8'h40);
    irq_is(1'b1);
    rd(SDT_OFF_INT_EN, 8'hff, 8'h40);
    wr(SDT_OFF_INT_FLAGS, 8'h00);
    rd(SDT_OFF_INT_FLAGS, 8'hff, 8'h73);
    wr(SDT_OFF_INT_FLAGS, 8'h41);
    rd(SDT_OFF_INT_FLAGS, 8'hff, 8'h32);
    irq_is(1'b0);
    // debugger break, frozen then running
    wr(SDT_OFF_LOW_CNT, 8'h10);
    debug_halt_i <= 1'b1;
    ticks(3);
    rd(SDT_OFF_LOW_CNT, 8'hff, 8'h10);
    wr(SDT_OFF_DEBUG, 8'h01);
    ticks(3);
    rd(SDT_OFF_LOW_CNT, 8'hff, cnt_after(8'h10, SDT_RST_PERIOD, 3));
    // compare channel one on the current count; set beats a clear
    wr(SDT_OFF_LOW_CMP0 + SDT_CMP_STRIDE, 8'h0d);
    rd(SDT_OFF_LOW_CMP0 + SDT_CMP_STRIDE, 8'hff, 8'h0d);
    chk("low_match", 8'h02, {5'h00, low_match_o});
    wr(SDT_OFF_INT_FLAGS, 8'h20);
    rd(SDT_OFF_INT_FLAGS, 8'h20, 8'h20);
    debug_halt_i <= 1'b0;
    // commands: restart, reserved, hard reset enabled then disabled
    wr(SDT_OFF_CMD_SET, 8'h0b);
    rd(SDT_OFF_LOW_CNT, 8'hff, 8'h00);
    rd(SDT_OFF_DEBUG, 8'hff, 8'h01);
    wr(SDT_OFF_HIGH_CNT, 8'h44);
    wr(SDT_OFF_CMD_SET, 8'h07);
    rd(SDT_OFF_HIGH_CNT, 8'hff, 8'h44);
    wr(SDT_OFF_CMD_SET, 8'h0f);
    rd(SDT_OFF_HIGH_CNT, 8'hff, 8'h44);
    wr(SDT_OFF_CTRL, 8'h00);
    wr(SDT_OFF_CMD_SET, 8'h0f);
    rd(SDT_OFF_HIGH_CNT, 8'hff, 8'h00);
    rd(SDT_OFF_DEBUG, 8'hff, 8'h00);
    rd(SDT_OFF_INT_EN, 8'hff, 8'h00);
    stop_test();
  end
endmodule : tb_top

bind sdt_split_timer sdt_split_timer_chk sdt_split_timer_chk_inst (.clk_i,
  .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tick_i, .event_i,
  .debug_halt_i, .irq_o, .low_count_o, .high_count_o, .low_match_o);
